// [hdl/ibc_pkg.sv]
package ibc_pkg;
    // register byte addresses
    localparam logic [11:0] IBC_CTRL_OFS = 12'h000;
    localparam logic [11:0] IBC_LEN_OFS = 12'h004;
    localparam logic [11:0] IBC_STAT_OFS = 12'h008;
    // control field positions
    localparam int IBC_HRISE_BIT = 15;
    localparam int IBC_HFALL_BIT = 14;
    localparam int IBC_LRISE_BIT = 13;
    localparam int IBC_LFALL_BIT = 12;
    localparam int IBC_FLTEN_BIT = 11;
    localparam int IBC_CLEN_BIT = 10;
    localparam int IBC_SELH_BIT = 5;
    localparam int IBC_SELL_BIT = 4;
    localparam int IBC_HH_BIT = 3;
    localparam int IBC_HL_BIT = 2;
    localparam int IBC_LH_BIT = 1;
    // implemented bits: 15..10 and 5..0
    localparam logic [15:0] IBC_CTRL_MASK = 16'hfc3f;
    localparam logic [15:0] IBC_CTRL_RST = 16'h0000;
    localparam logic [9:0] IBC_LEN_RST = 10'h000;
    localparam int IBC_LEN_W = 10;
endpackage

// [hdl/ibc_sync.sv]
`timescale 1ns/10ps
// two-flop synchroniser per bit
module ibc_sync #(
    parameter int W = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    // first stage read only by the second
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= '0;
            q <= '0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// [hdl/ibc_top.sv]
`timescale 1ns/10ps
// Summary of operation
// - control bit 12 lets low-side falling edge start blanking counter
// - bit 11 applies leading-edge blanking to the fault input
// - bit 10 applies leading-edge blanking to the current-limit input
// - bits 9 to 6 read zero and ignore writes
// - bit 5 blanks inputs while the select signal is high
// - bit 4 blanks inputs while the select signal is low
// - bit 3 blanks inputs while high-side output is high
// - bit 2 blanks inputs while high-side output is low
// - bit 1 blanks inputs while low-side output is high
// - bits 15,14,13 enable high rise, high fall, low rise triggers
module ibc_top
    import ibc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // pwm and select pins
    input wire logic high_side_pwm_out,
    input wire logic low_side_pwm_out,
    input wire logic blank_select,
    // raw protection inputs
    input wire logic fault_in,
    input wire logic curlim_in,
    // masked protection outputs and blanking flag
    output logic fault_masked,
    output logic curlim_masked,
    output logic blank_active
);
    logic [3:0] sync_q;
    logic hs, ls, sel, flt_s, cl_s;
    logic hs_d, ls_d;
    logic [15:0] ctrl, next_ctrl;
    logic [IBC_LEN_W-1:0] len, next_len;
    logic [IBC_LEN_W-1:0] cnt, next_cnt;
    logic [31:0] next_prdata;
    logic next_pready, next_pslverr;
    logic next_fault_masked, next_curlim_masked, next_blank_active;
    logic trig, state_blank, leb_run;
    logic prot_q;
    logic prot_meta;

    // pin synchronisers
    ibc_sync #(.W(4)) u_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d({high_side_pwm_out, low_side_pwm_out, blank_select, fault_in}),
        .q(sync_q)
    );
    assign hs = sync_q[3];
    assign ls = sync_q[2];
    assign sel = sync_q[1];
    assign flt_s = sync_q[0];
    assign cl_s = prot_q;

    // current-limit synchroniser
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            prot_meta <= 1'b0;
            prot_q <= 1'b0;
        end else begin
            prot_meta <= curlim_in;
            prot_q <= prot_meta;
        end
    end

    // edge triggers
    always_comb begin
        trig = 1'b0;
        if (ctrl[IBC_HRISE_BIT] && hs && !hs_d) begin
            trig = 1'b1;
        end
        if (ctrl[IBC_HFALL_BIT] && !hs && hs_d) begin
            trig = 1'b1;
        end
        if (ctrl[IBC_LRISE_BIT] && ls && !ls_d) begin
            trig = 1'b1;
        end
        if (ctrl[IBC_LFALL_BIT] && !ls && ls_d) begin
            trig = 1'b1;
        end
    end

    // state blanking conditions
    always_comb begin
        state_blank = (ctrl[IBC_SELH_BIT] && sel)
            || (ctrl[IBC_SELL_BIT] && !sel)
            || (ctrl[IBC_HH_BIT] && hs)
            || (ctrl[IBC_HL_BIT] && !hs)
            || (ctrl[IBC_LH_BIT] && ls);
    end

    assign leb_run = (cnt != '0);

    // counter next value
    always_comb begin
        next_cnt = cnt;
        if (trig) begin
            next_cnt = len;
        end else if (leb_run) begin
            next_cnt = cnt - 1'b1;
        end
    end

    // masking of the protection inputs
    always_comb begin
        next_blank_active = state_blank || leb_run;
        next_fault_masked = flt_s
            && !(state_blank || (leb_run && ctrl[IBC_FLTEN_BIT]));
        next_curlim_masked = cl_s
            && !(state_blank || (leb_run && ctrl[IBC_CLEN_BIT]));
    end

    // apb register access, one wait-free access phase
    always_comb begin
        next_ctrl = ctrl;
        next_len = len;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        if (psel && !penable) begin
            next_pready = 1'b1;
            next_prdata = 32'h0000_0000;
            unique case (paddr)
                IBC_CTRL_OFS: begin
                    next_prdata = {16'h0000, ctrl};
                end
                IBC_LEN_OFS: begin
                    next_prdata = {22'h000000, len};
                end
                IBC_STAT_OFS: begin
                    next_prdata = {22'h000000, cnt};
                    next_pslverr = pwrite;
                end
                default: begin
                    next_pslverr = 1'b1;
                end
            endcase
        end
        // write lands on the access edge that samples pready
        if (psel && penable && pready && pwrite) begin
            unique case (paddr)
                IBC_CTRL_OFS: begin
                    next_ctrl = pwdata[15:0] & IBC_CTRL_MASK;
                end
                IBC_LEN_OFS: begin
                    next_len = pwdata[IBC_LEN_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // state registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= IBC_CTRL_RST;
            len <= IBC_LEN_RST;
            cnt <= '0;
            hs_d <= 1'b0;
            ls_d <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            fault_masked <= 1'b0;
            curlim_masked <= 1'b0;
            blank_active <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            len <= next_len;
            cnt <= next_cnt;
            hs_d <= hs;
            ls_d <= ls;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            fault_masked <= next_fault_masked;
            curlim_masked <= next_curlim_masked;
            blank_active <= next_blank_active;
        end
    end

    // checks
    property p_lfall;
        @(posedge clk) disable iff (sys_rst)
        (ctrl[IBC_LFALL_BIT] && ls_d && !ls && len != '0) |=> leb_run;
    endproperty
    a_lfall: assert property (p_lfall) else $error("low fall no trigger");

    property p_flt;
        @(posedge clk) disable iff (sys_rst)
        (leb_run && ctrl[IBC_FLTEN_BIT]) |=> !fault_masked;
    endproperty
    a_flt: assert property (p_flt) else $error("fault not blanked");

    property p_cl;
        @(posedge clk) disable iff (sys_rst)
        (leb_run && ctrl[IBC_CLEN_BIT]) |=> !curlim_masked;
    endproperty
    a_cl: assert property (p_cl) else $error("curlim not blanked");

    property p_resv;
        @(posedge clk) disable iff (sys_rst)
        ctrl[9:6] == 4'h0;
    endproperty
    a_resv: assert property (p_resv) else $error("reserved bits set");

    property p_selh;
        @(posedge clk) disable iff (sys_rst)
        (ctrl[IBC_SELH_BIT] && sel) |=> (blank_active && !fault_masked);
    endproperty
    a_selh: assert property (p_selh) else $error("select high no blank");

    property p_sell;
        @(posedge clk) disable iff (sys_rst)
        (ctrl[IBC_SELL_BIT] && !sel) |=> !curlim_masked;
    endproperty
    a_sell: assert property (p_sell) else $error("select low no blank");

    property p_hh;
        @(posedge clk) disable iff (sys_rst)
        (ctrl[IBC_HH_BIT] && hs) |=> blank_active;
    endproperty
    a_hh: assert property (p_hh) else $error("high side high no blank");

    property p_hl;
        @(posedge clk) disable iff (sys_rst)
        (ctrl[IBC_HL_BIT] && !hs) |=> blank_active;
    endproperty
    a_hl: assert property (p_hl) else $error("high side low no blank");

    property p_lh;
        @(posedge clk) disable iff (sys_rst)
        (ctrl[IBC_LH_BIT] && ls) |=> blank_active;
    endproperty
    a_lh: assert property (p_lh) else $error("low side high no blank");

    property p_restart;
        @(posedge clk) disable iff (sys_rst)
        trig |=> (cnt == $past(len));
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

    property p_pass;
        @(posedge clk) disable iff (sys_rst)
        (!state_blank && !leb_run && flt_s) |=> fault_masked;
    endproperty
    a_pass: assert property (p_pass) else $error("fault lost");

    property p_pass_cl;
        @(posedge clk) disable iff (sys_rst)
        (!state_blank && !leb_run && cl_s) |=> curlim_masked;
    endproperty
    a_pass_cl: assert property (p_pass_cl) else $error("curlim lost");

    property p_count;
        @(posedge clk) disable iff (sys_rst)
        (leb_run && !trig) |=> (cnt == $past(cnt) - 1'b1);
    endproperty
    a_count: assert property (p_count) else $error("count step");

    property p_hrise;
        @(posedge clk) disable iff (sys_rst)
        (ctrl[IBC_HRISE_BIT] && hs && !hs_d && len != '0) |=> leb_run;
    endproperty
    a_hrise: assert property (p_hrise) else $error("high rise idle");

    property p_hfall;
        @(posedge clk) disable iff (sys_rst)
        (ctrl[IBC_HFALL_BIT] && !hs && hs_d && len != '0) |=> leb_run;
    endproperty
    a_hfall: assert property (p_hfall) else $error("high fall idle");

    property p_lrise;
        @(posedge clk) disable iff (sys_rst)
        (ctrl[IBC_LRISE_BIT] && ls && !ls_d && len != '0) |=> leb_run;
    endproperty
    a_lrise: assert property (p_lrise) else $error("low rise idle");

    property p_wr_ctrl;
        @(posedge clk) disable iff (sys_rst)
        (psel && penable && pready && pwrite && paddr == IBC_CTRL_OFS)
            |=> (ctrl == ($past(pwdata[15:0]) & IBC_CTRL_MASK));
    endproperty
    a_wr_ctrl: assert property (p_wr_ctrl) else $error("ctrl write");

    property p_pready;
        @(posedge clk) disable iff (sys_rst)
        pready |=> !pready;
    endproperty
    a_pready: assert property (p_pready) else $error("pready too long");
endmodule

// [tb/ibc_far_side.sv]
`timescale 1ns/10ps
// pwm stage and protection sources driven to bench-requested levels
module ibc_far_side (
    // clock
    input wire logic clk,
    // requested levels: hs, ls, select, fault, current limit
    input wire logic [4:0] req,
    // pins toward the block
    output logic high_side_pwm_out,
    output logic low_side_pwm_out,
    output logic blank_select,
    output logic fault_in,
    output logic curlim_in
);
    // pins move only just after a clock edge
    always_ff @(posedge clk) begin
        {high_side_pwm_out, low_side_pwm_out, blank_select, fault_in,
            curlim_in} <= req;
    end
endmodule

// [tb/tb_ibc_top.sv]
`timescale 1ns/10ps
module tb_ibc_top;
    import ibc_pkg::*;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, fault_masked, curlim_masked, blank_active;
    logic high_side_pwm_out, low_side_pwm_out, blank_select;
    logic fault_in, curlim_in;
    logic [2:0] outs;
    logic [4:0] req = 5'h03;
    int fail_count = 0;
    int tests_run = 0;
    // clock and observed outputs
    always #10 clk = ~clk;
    assign outs = {blank_active, fault_masked, curlim_masked};
    ibc_far_side far (.clk, .req, .high_side_pwm_out, .low_side_pwm_out,
        .blank_select, .fault_in, .curlim_in);
    ibc_top dut (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .high_side_pwm_out, .low_side_pwm_out,
        .blank_select, .fault_in, .curlim_in, .fault_masked, .curlim_masked,
        .blank_active);
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // compare and count
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wait_cyc(int n);
        repeat (n) @(posedge clk);
    endtask
    // one apb transfer, request held until pready sampled high
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            fail_count++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    // reset value, dead bits, refused addresses
    task automatic t_regs();
        apb(1'b0, IBC_CTRL_OFS, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        chk("read no err", 32'h0, 32'(err));
        apb(1'b0, IBC_STAT_OFS, 32'h0);
        chk("status idle", 32'h0, rd);
        apb(1'b1, IBC_CTRL_OFS, 32'hffff_ffff);
        apb(1'b0, IBC_CTRL_OFS, 32'h0);
        chk("ctrl readback", 32'h0000_fc3f, rd);
        apb(1'b1, 12'h00c, 32'h1);
        chk("unmapped err", 32'h1, 32'(err));
        apb(1'b1, IBC_STAT_OFS, 32'h1);
        chk("status write err", 32'h1, 32'(err));
        apb(1'b1, IBC_CTRL_OFS, 32'h0);
        $display("register test done");
    endtask
    // each state condition blanks at its level only
    task automatic t_state();
        logic [2:0] on [5] = '{3'h1, 3'h0, 3'h4, 3'h0, 3'h2};
        logic [2:0] mk [5] = '{3'h1, 3'h1, 3'h4, 3'h4, 3'h2};
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, IBC_CTRL_OFS, 32'h1 << (5 - i));
            req <= {on[i], 2'h3};
            wait_cyc(6);
            chk("blanked", 32'h4, 32'(outs));
            req <= {on[i] ^ mk[i], 2'h3};
            wait_cyc(6);
            chk("open", 32'h3, 32'(outs));
        end
        $display("state blanking test done");
    endtask
    // set pins before the edge, then make the edge of trigger bit b
    task automatic trig(int b);
        req[4] <= (b == 14);
        req[3] <= (b == 12);
        wait_cyc(4);
        if (b >= 14) begin
            req[4] <= (b == 15);
        end else begin
            req[3] <= (b == 13);
        end
    endtask
    // edge triggers, per-input enables, counter length and restart
    task automatic t_leb();
        req <= 5'h03;
        apb(1'b1, IBC_LEN_OFS, 32'h14);
        apb(1'b0, IBC_LEN_OFS, 32'h0);
        chk("len readback", 32'h14, rd);
        for (int b = 12; b < 16; b++) begin
            apb(1'b1, IBC_CTRL_OFS, 32'h0c00);
            trig(b);
            wait_cyc(6);
            chk("edge off", 32'h3, 32'(outs));
            apb(1'b1, IBC_CTRL_OFS, 32'h0c00 | (32'h1 << b));
            trig(b);
            wait_cyc(6);
            chk("edge blank", 32'h4, 32'(outs));
            wait_cyc(30);
            chk("edge end", 32'h3, 32'(outs));
            apb(1'b1, IBC_CTRL_OFS, 32'h1 << b);
            trig(b);
            wait_cyc(6);
            chk("inputs pass", 32'h3, 32'(outs[1:0]));
            wait_cyc(30);
        end
        apb(1'b1, IBC_CTRL_OFS, 32'h8c00);
        trig(15);
        wait_cyc(10);
        trig(15);
        wait_cyc(16);
        chk("restart", 32'h4, 32'(outs));
        wait_cyc(30);
        chk("restart end", 32'h3, 32'(outs));
        apb(1'b1, IBC_LEN_OFS, 32'h0);
        trig(15);
        wait_cyc(6);
        chk("zero length", 32'h3, 32'(outs));
        $display("edge blanking test done");
    endtask
    // main sequence
    initial begin
        wait_cyc(2);
        sys_rst <= 1'b0;
        t_regs();
        t_state();
        t_leb();
        wrap_up();
    end
endmodule
